/* File: wdt_pkg.sv */
package wdt_pkg;
  localparam logic [7:0] INDEX_PORT_ADDR = 8'h2E;
  localparam logic [7:0] DATA_PORT_ADDR = 8'h2F;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'hAA;
  localparam logic [7:0] IDX_LDEV_SELECT = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_TIME_UNIT = 8'hF0;
  localparam logic [7:0] IDX_TIMEOUT = 8'hF1;
  localparam logic [7:0] WDT_LDEV = 8'h08;
  localparam logic [7:0] UNIT_SECONDS = 8'h00;
  localparam logic [7:0] UNIT_MINUTES = 8'h08;
  localparam logic [7:0] ACTIVATE_ON = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int CLK_HZ = 100_000_000;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int RESET_PULSE_CYCLES = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  typedef enum logic [1:0] {
    LOCKED = 2'b00,
    KEY_ONCE = 2'b01,
    UNLOCKED = 2'b10
  } cfg_state_e;
endpackage

/* File: system_watchdog_timer.sv */
`timescale 1ns/1ps
module system_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int TICKS_PER_SECOND = CLK_HZ
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire io_req_s io,
  output logic [7:0] rdata,
  output logic sys_reset,
  output logic wdt_running
);
  if (TICKS_PER_SECOND < 1)
  begin : g_bad_ticks
    $error("TICKS_PER_SECOND must be at least 1");
  end

  cfg_state_e cfg_state;
  logic [7:0] index_reg;
  logic [7:0] logical_device_select;
  logic [7:0] watchdog_activate;
  logic [7:0] watchdog_time_unit;
  logic [7:0] watchdog_timeout_count;
  logic [31:0] sec_div;
  logic [5:0] min_div;
  logic [7:0] count;
  logic [4:0] rst_cnt;
  logic unit_tick;
  logic cfg_open;
  logic idx_wr;
  logic data_wr;
  logic wdt_sel;
  logic load;
  logic sec_tick;

  assign cfg_open = (cfg_state == UNLOCKED);
  assign idx_wr = io.wr && io.addr == INDEX_PORT_ADDR;
  assign data_wr = io.wr && io.addr == DATA_PORT_ADDR && cfg_open;
  assign wdt_sel = logical_device_select == WDT_LDEV;
  assign load = data_wr && wdt_sel && index_reg == IDX_TIMEOUT;
  assign sec_tick = sec_div == 32'(TICKS_PER_SECOND - 1);

  // unlock sequence
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_state <= LOCKED;
    else if (idx_wr)
    begin
      case (cfg_state)
        LOCKED: cfg_state <= (io.wdata == UNLOCK_KEY) ? KEY_ONCE : LOCKED;
        KEY_ONCE: cfg_state <= (io.wdata == UNLOCK_KEY) ? UNLOCKED : LOCKED;
        UNLOCKED: cfg_state <= (io.wdata == LOCK_KEY) ? LOCKED : UNLOCKED;
        default: cfg_state <= LOCKED;
      endcase
    end
    else if (io.wr && cfg_state == KEY_ONCE)
      cfg_state <= LOCKED;
  end

  // index latch
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      index_reg <= ZERO_BYTE;
    else if (idx_wr && cfg_open)
      index_reg <= io.wdata;
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      logical_device_select <= ZERO_BYTE;
      watchdog_activate <= ZERO_BYTE;
      watchdog_time_unit <= UNIT_SECONDS;
      watchdog_timeout_count <= ZERO_BYTE;
    end
    else if (data_wr)
    begin
      if (index_reg == IDX_LDEV_SELECT)
        logical_device_select <= io.wdata;
      else if (wdt_sel && index_reg == IDX_ACTIVATE)
        watchdog_activate <= io.wdata;
      else if (wdt_sel && index_reg == IDX_TIME_UNIT)
        watchdog_time_unit <= io.wdata;
      else if (load)
        watchdog_timeout_count <= io.wdata;
    end
  end

  // read data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= ZERO_BYTE;
    else if (io.rd && io.addr == INDEX_PORT_ADDR)
      rdata <= index_reg;
    else if (io.rd && io.addr == DATA_PORT_ADDR && cfg_open)
    begin
      case (index_reg)
        IDX_LDEV_SELECT: rdata <= logical_device_select;
        IDX_ACTIVATE: rdata <= wdt_sel ? watchdog_activate : ZERO_BYTE;
        IDX_TIME_UNIT: rdata <= wdt_sel ? watchdog_time_unit : ZERO_BYTE;
        IDX_TIMEOUT: rdata <= wdt_sel ? count : ZERO_BYTE;
        default: rdata <= ZERO_BYTE;
      endcase
    end
  end

  // time base: seconds, optionally divided to minutes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_div <= '0;
      min_div <= '0;
      unit_tick <= 1'b0;
    end
    else if (load || watchdog_activate != ACTIVATE_ON)
    begin
      sec_div <= '0;
      min_div <= '0;
      unit_tick <= 1'b0;
    end
    else
    begin
      sec_div <= sec_tick ? '0 : sec_div + 32'd1;
      unit_tick <= 1'b0;
      if (sec_tick)
      begin
        if (watchdog_time_unit == UNIT_MINUTES)
        begin
          min_div <= (min_div == 6'(SECONDS_PER_MINUTE - 1)) ? '0 : min_div + 6'd1;
          unit_tick <= min_div == 6'(SECONDS_PER_MINUTE - 1);
        end
        else
          unit_tick <= 1'b1;
      end
    end
  end

  // countdown
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= ZERO_BYTE;
    else if (load)
      count <= io.wdata;
    else if (watchdog_activate == ACTIVATE_ON && unit_tick && count != ZERO_BYTE)
      count <= count - 8'd1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdt_running <= 1'b0;
    else
      wdt_running <= watchdog_activate == ACTIVATE_ON && count != ZERO_BYTE;
  end

  // reset pulse on expiry
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_reset <= 1'b0;
      rst_cnt <= '0;
    end
    else if (rst_cnt != '0)
    begin
      rst_cnt <= rst_cnt - 5'd1;
      sys_reset <= rst_cnt != 5'd1;
    end
    // a reload in the final tick cycle wins over expiry
    else if (watchdog_activate == ACTIVATE_ON && unit_tick && count == 8'd1 && !load)
    begin
      sys_reset <= 1'b1;
      rst_cnt <= 5'(RESET_PULSE_CYCLES);
    end
  end

  a_unlock_needs_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(cfg_open) |-> $past(idx_wr) && $past(io.wdata) == UNLOCK_KEY && $past(cfg_state) == KEY_ONCE)
    else $error("unlock without key");
  a_locked_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (io.wr && io.addr == DATA_PORT_ADDR && !cfg_open) |=> $stable(watchdog_timeout_count))
    else $error("write accepted while locked");
  a_expiry_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (watchdog_activate == ACTIVATE_ON && unit_tick && count == 8'd1 && !load && rst_cnt == '0)
    |=> sys_reset && count == ZERO_BYTE)
    else $error("no reset on expiry");
  a_count_decrements: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (watchdog_activate == ACTIVATE_ON && unit_tick && count > 8'd1 && !load)
    |=> count == $past(count) - 8'd1)
    else $error("count did not decrement");
  a_reload_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load |=> count == $past(io.wdata) && watchdog_timeout_count == $past(io.wdata))
    else $error("reload value wrong");
  a_disabled_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (watchdog_activate != ACTIVATE_ON && !load) |=> $stable(count))
    else $error("count moved while disabled");
  a_minute_unit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(watchdog_time_unit) == UNIT_MINUTES && unit_tick)
    |-> $past(min_div) == 6'(SECONDS_PER_MINUTE - 1))
    else $error("minute tick too early");
  a_reset_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sys_reset) |-> sys_reset [*8])
    else $error("reset pulse too short");
  a_other_device_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (data_wr && !wdt_sel && index_reg != IDX_LDEV_SELECT) |=> $stable(watchdog_activate))
    else $error("activate written for other device");
  a_idle_no_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count == ZERO_BYTE && rst_cnt == '0) |=> !sys_reset)
    else $error("reset without expiry");
endmodule

/* File: tb_system_watchdog_timer.sv */
`timescale 1ns/1ps
module tb_system_watchdog_timer
  import wdt_pkg::*;
;
  localparam int T = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  io_req_s io = '0;
  logic [7:0] rdata;
  logic sys_reset;
  logic wdt_running;
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 42;
  int width = 0;
  int pulses = 0;
  int n;
  int p;
  logic [7:0] rq[$];
  int wq[$];

  always #5 ref_clk = ~ref_clk;

  system_watchdog_timer #(.TICKS_PER_SECOND(T)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .io(io),
    .rdata(rdata), .sys_reset(sys_reset), .wdt_running(wdt_running));

  function automatic void check(bit ok, string msg);
    tests_run++;
    if (!ok)
    begin
      $display("unexpected at %0t: %s", $time, msg);
      n_errors++;
    end
  endfunction

  task conclude;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    io <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
  endtask

  task set(input logic [7:0] i, input logic [7:0] v);
    wr(INDEX_PORT_ADDR, i);
    wr(DATA_PORT_ADDR, v);
  endtask

  task idle;
    io <= '0;
    @(posedge ref_clk);
  endtask

  task rd_chk(input logic [7:0] e);
    rq.push_back(e);
    io <= '{wr: 1'b0, rd: 1'b1, addr: DATA_PORT_ADDR, wdata: 8'h00};
    @(posedge ref_clk);
    idle();
  endtask

  task expire(input int exp);
    int k;
    k = 0;
    wq.push_back(RESET_PULSE_CYCLES);
    while (sys_reset !== 1'b1 && k < exp + 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    check(k >= exp - 2 && k <= exp + 3, "expiry time");
    repeat (RESET_PULSE_CYCLES + 4) @(posedge ref_clk);
  endtask

  // result watcher: read data and reset pulses
  always @(posedge ref_clk)
  begin
    rd_seen <= io.rd;
    if (rd_seen === 1'b1)
      check(rq.size() > 0 && rdata === rq.pop_front(), "read data");
    if (sys_reset === 1'b1)
      width++;
    else if (width != 0)
    begin
      check(wq.size() > 0 && width == wq.pop_front(), "pulse width");
      pulses++;
      width = 0;
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle();
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    wr(INDEX_PORT_ADDR, ZERO_BYTE);
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    set(IDX_LDEV_SELECT, WDT_LDEV);
    set(IDX_ACTIVATE, ACTIVATE_ON);
    set(IDX_TIMEOUT, 8'h05);
    repeat (2) idle();
    check(wdt_running === 1'b0, "broken key unlocked");
    n = 1 + $unsigned($random(seed)) % 3;
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    set(IDX_LDEV_SELECT, WDT_LDEV);
    set(IDX_ACTIVATE, ACTIVATE_ON);
    set(IDX_TIME_UNIT, UNIT_SECONDS);
    set(IDX_TIMEOUT, n[7:0]);
    repeat (2) idle();
    check(wdt_running === 1'b1, "not running");
    rd_chk(n[7:0]);
    p = pulses;
    repeat (3)
    begin
      repeat (n * T - 8) @(posedge ref_clk);
      set(IDX_TIMEOUT, n[7:0]);
      idle();
    end
    check(pulses == p, "reset despite reload");
    expire(n * T);
    check(wdt_running === 1'b0, "running after expiry");
    rd_chk(8'h00);
    set(IDX_TIME_UNIT, UNIT_MINUTES);
    set(IDX_TIMEOUT, 8'h01);
    idle();
    expire(SECONDS_PER_MINUTE * T);
    set(IDX_TIME_UNIT, UNIT_SECONDS);
    set(IDX_TIMEOUT, 8'h02);
    set(IDX_ACTIVATE, ZERO_BYTE);
    repeat (2) idle();
    check(wdt_running === 1'b0, "running after disable");
    p = pulses;
    repeat (40) @(posedge ref_clk);
    check(pulses == p, "reset while disabled");
    set(IDX_LDEV_SELECT, ZERO_BYTE);
    set(IDX_ACTIVATE, ACTIVATE_ON);
    repeat (2) idle();
    check(wdt_running === 1'b0, "other device enabled");
    wr(INDEX_PORT_ADDR, LOCK_KEY);
    set(IDX_LDEV_SELECT, WDT_LDEV);
    set(IDX_ACTIVATE, ACTIVATE_ON);
    repeat (2) idle();
    check(wdt_running === 1'b0, "write after lock");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(sys_reset === 1'b0 && wdt_running === 1'b0 && rdata === 8'h00, "outputs not reset");
    rst_n <= 1'b1;
    idle();
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    wr(INDEX_PORT_ADDR, UNLOCK_KEY);
    set(IDX_LDEV_SELECT, WDT_LDEV);
    wr(INDEX_PORT_ADDR, IDX_TIMEOUT);
    rd_chk(ZERO_BYTE);
    repeat (2) idle();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    conclude();
  end
endmodule
